// ==== core/wkd_filter.sv ====
// Synchroniser and glitch filter for one wake pin
`timescale 1ns/1ps
module wkd_filter
  import wkd_pkg::*;
#(
  parameter int SHORT_CYC = FILT_SHORT_CYC,
  parameter int LONG_CYC = FILT_LONG_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic pin_in,
  input wire logic active_in,
  input wire logic long_sel_in,
  output logic live_out,
  output logic level_out,
  output logic edge_out
);
  import wkd_pkg::*;

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic stable;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] limit;
  wkd_flt_t state_reg;

  // ----------------------------------------------------------------
  // Three-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else if (ce_in) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign stable = (s2_reg == s3_reg);
  assign live_out = s3_reg;
  assign limit = long_sel_in ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC);

  // ----------------------------------------------------------------
  // Filter; level is held while the sense window is closed
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= FLT_INIT;
      cnt_reg <= '0;
      level_out <= 1'b0;
      edge_out <= 1'b0;
    end else if (ce_in) begin
      edge_out <= 1'b0;
      unique case (state_reg)
        FLT_INIT: begin
          // Take the pin level quietly so reset causes no false edge
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (cnt_reg[1:0] == SYNC_SETTLE) begin
            level_out <= s3_reg;
            cnt_reg <= '0;
            state_reg <= FLT_IDLE;
          end
        end
        FLT_IDLE: begin
          if (active_in && stable && s3_reg != level_out) begin
            cnt_reg <= CNT_W'(1);
            state_reg <= FLT_COUNT;
          end
        end
        FLT_COUNT: begin
          if (!active_in || (stable && s3_reg == level_out)) begin
            state_reg <= FLT_IDLE;
          end else if (cnt_reg >= limit) begin
            level_out <= s3_reg;
            edge_out <= 1'b1;
            state_reg <= FLT_IDLE;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        default: state_reg <= FLT_IDLE;
      endcase
    end
  end

endmodule

// ==== core/wkd_pkg.sv ====
// Constants, types and a helper function for the wake input detector
// Function
// - Each wake input signals an event on both rising and falling edges.
// - Edge raises interrupt in normal or stop mode, wakes in sleep or fail-safe.
// - Software selects static (always watched) or cyclic (timer window) sensing.
// - Static sensing offers two glitch filter durations against spurious wakes.
// - Filter starts at threshold crossing; crossing back before expiry cancels it.
// - A per-pin bit in the wake enable register enables wake capability.
// - A per-pin source flag in wake status records which pin caused a wake.
// - Pin levels are readable in normal and stop mode, even for disabled pins.
// - During cyclic sensing the level register shows the last sampled level.
// - Alternate output pins as wake inputs use 16 us static filter, own status.
// - Pull code 00 floating, 01 pull-down, 10 pull-up.
// - Pull code 11 switches: pull-up while high, pull-down while low.
// - Detect code 00 static 16 us filter, 01 static 64 us filter.
// - Detect code 10 cyclic on timer A, 11 on timer B, both 16 us filter.
// - Pull and filter selections live in two separate writable registers.
package wkd_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int WKD_NPIN = 3;
  localparam int WKD_NALT = 2;
  localparam int WKD_NSRC = 5;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_WAKE_EN = 8'h00;
  localparam logic [7:0] OFS_PULL = 8'h04;
  localparam logic [7:0] OFS_FILT = 8'h08;
  localparam logic [7:0] OFS_SRC = 8'h0c;
  localparam logic [7:0] OFS_ALT_SRC = 8'h10;
  localparam logic [7:0] OFS_LEVEL = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_CLR = 8'h1c;
  localparam logic [7:0] OFS_INT_EN = 8'h20;
  localparam logic [7:0] OFS_MODE = 8'h24;
  localparam logic [4:0] WAKE_EN_RST = 5'h00;
  localparam logic [5:0] PULL_RST = 6'h00;
  localparam logic [5:0] FILT_RST = 6'h00;
  localparam logic [4:0] INT_EN_RST = 5'h00;
  localparam int ALT_POS = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int FILT_SHORT_US = 16;
  localparam int FILT_LONG_US = 64;
  localparam int FILT_SHORT_CYC = FILT_SHORT_US * CLK_MHZ;
  localparam int FILT_LONG_CYC = FILT_LONG_US * CLK_MHZ;
  localparam int CNT_W = 14;
  localparam logic [1:0] SYNC_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;
  localparam logic [1:0] DET_STATIC_SHORT = 2'h0;
  localparam logic [1:0] DET_STATIC_LONG = 2'h1;
  localparam logic [1:0] DET_CYCLIC_A = 2'h2;
  localparam logic [1:0] DET_CYCLIC_B = 2'h3;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_STOP = 2'b01,
    MODE_SLEEP = 2'b10,
    MODE_FAILSAFE = 2'b11
  } wkd_mode_t;

  typedef enum logic [1:0] {
    FLT_INIT = 2'b00,
    FLT_IDLE = 2'b01,
    FLT_COUNT = 2'b10
  } wkd_flt_t;

  // Two-bit per-pin field of a packed configuration word
  function automatic logic [1:0] wkd_field(input logic [5:0] r, input int idx);
    return r[2*idx +: 2];
  endfunction

endpackage

// ==== core/wkd_top.sv ====
// Wake input detector: APB registers, per-pin filters, pulls and events
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module wkd_top
  import wkd_pkg::*;
#(
  parameter int SHORT_CYC = FILT_SHORT_CYC,
  parameter int LONG_CYC = FILT_LONG_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [wkd_pkg::WKD_NPIN-1:0] wake_pin_in,
  input wire logic [wkd_pkg::WKD_NALT-1:0] alt_output_pin_in,
  input wire logic timer_a_on_in,
  input wire logic timer_b_on_in,
  input wire logic [1:0] dev_mode_in,
  output logic [wkd_pkg::WKD_NPIN-1:0] pull_up_out,
  output logic [wkd_pkg::WKD_NPIN-1:0] pull_down_out,
  output logic irq_out,
  output logic wake_out
);
  import wkd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [4:0] wake_enable_ctrl_reg;
  logic [5:0] pull_config_reg;
  logic [5:0] filter_config_reg;
  logic [4:0] int_en_reg;
  logic [4:0] src_flags_reg;
  logic [4:0] src_flags_next;
  logic [4:0] set_vec;
  logic [4:0] clr_vec;
  logic [WKD_NSRC-1:0] all_pins;
  logic [WKD_NSRC-1:0] active_vec;
  logic [WKD_NSRC-1:0] long_vec;
  logic [WKD_NSRC-1:0] live_vec;
  logic [WKD_NSRC-1:0] level_vec;
  logic [WKD_NSRC-1:0] edge_vec;
  logic [WKD_NSRC-1:0] cyclic_vec;
  logic [WKD_NSRC-1:0] level_view;
  logic setup_ok;
  logic access;
  logic commit_wr;
  logic mapped;
  logic [31:0] rd_mux;
  logic awake_mode;
  wkd_mode_t mode;

  assign mode = wkd_mode_t'(dev_mode_in);
  assign awake_mode = (mode == MODE_NORMAL) || (mode == MODE_STOP);
  assign all_pins = {alt_output_pin_in, wake_pin_in};

  // ----------------------------------------------------------------
  // Sense selection per pin
  // ----------------------------------------------------------------
  always_comb begin
    active_vec = '1;
    long_vec = '0;
    cyclic_vec = '0;
    for (int i = 0; i < WKD_NPIN; i++) begin
      unique case (wkd_field(filter_config_reg, i))
        DET_STATIC_SHORT: active_vec[i] = 1'b1;
        DET_STATIC_LONG: long_vec[i] = 1'b1;
        DET_CYCLIC_A: begin
          active_vec[i] = timer_a_on_in;
          cyclic_vec[i] = 1'b1;
        end
        DET_CYCLIC_B: begin
          active_vec[i] = timer_b_on_in;
          cyclic_vec[i] = 1'b1;
        end
      endcase
    end
    // Alternate pins always static with the short filter
    for (int j = WKD_NPIN; j < WKD_NSRC; j++) begin
      active_vec[j] = 1'b1;
      long_vec[j] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Filters
  // ----------------------------------------------------------------
  for (genvar g = 0; g < WKD_NSRC; g++) begin : g_flt
    wkd_filter #(
      .SHORT_CYC(SHORT_CYC),
      .LONG_CYC(LONG_CYC)
    ) u_flt (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .pin_in(all_pins[g]),
      .active_in(active_vec[g]),
      .long_sel_in(long_vec[g]),
      .live_out(live_vec[g]),
      .level_out(level_vec[g]),
      .edge_out(edge_vec[g])
    );
  end

  // Cyclic pins show the level captured in the last window
  assign level_view = (cyclic_vec & level_vec) | (~cyclic_vec & live_vec);

  // ----------------------------------------------------------------
  // APB handshake: one wait state, write commits with pready high
  // ----------------------------------------------------------------
  assign setup_ok = psel_in && penable_in;
  assign access = setup_ok && !pready_out;
  assign commit_wr = setup_ok && pready_out && pwrite_in;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_in)
      OFS_WAKE_EN: rd_mux[4:0] = wake_enable_ctrl_reg;
      OFS_PULL: rd_mux[5:0] = pull_config_reg;
      OFS_FILT: rd_mux[5:0] = filter_config_reg;
      OFS_SRC: rd_mux[2:0] = src_flags_reg[2:0];
      OFS_ALT_SRC: rd_mux[1:0] = src_flags_reg[4:3];
      OFS_LEVEL: rd_mux[4:0] = level_view;
      OFS_INT_STAT: rd_mux[4:0] = src_flags_reg;
      OFS_INT_CLR: rd_mux = 32'h0000_0000;
      OFS_INT_EN: rd_mux[4:0] = int_en_reg;
      OFS_MODE: rd_mux[1:0] = dev_mode_in;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      pready_out <= access;
      if (access) begin
        pslverr_out <= !mapped;
        prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
      end else begin
        pslverr_out <= 1'b0;
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_enable_ctrl_reg <= WAKE_EN_RST;
      pull_config_reg <= PULL_RST;
      filter_config_reg <= FILT_RST;
      int_en_reg <= INT_EN_RST;
    end else if (ce_in && commit_wr) begin
      unique case (paddr_in)
        OFS_WAKE_EN: wake_enable_ctrl_reg <= pwdata_in[4:0];
        OFS_PULL: pull_config_reg <= pwdata_in[5:0];
        OFS_FILT: filter_config_reg <= pwdata_in[5:0];
        OFS_INT_EN: int_en_reg <= pwdata_in[4:0];
        default: int_en_reg <= int_en_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wake source flags; a new event beats a clear in the same cycle
  // ----------------------------------------------------------------
  assign set_vec = edge_vec & wake_enable_ctrl_reg;
  assign clr_vec = (commit_wr && paddr_in == OFS_INT_CLR) ? pwdata_in[4:0] : 5'h00;
  assign src_flags_next = (src_flags_reg & ~clr_vec) | set_vec;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      src_flags_reg <= 5'h00;
    end else if (ce_in) begin
      src_flags_reg <= src_flags_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt in active modes, wake request in low-power modes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
      wake_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= awake_mode && |(src_flags_next & int_en_reg);
      wake_out <= !awake_mode && |set_vec;
    end
  end

  // ----------------------------------------------------------------
  // Pull current control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pull_up_out <= '0;
      pull_down_out <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < WKD_NPIN; i++) begin
        unique case (wkd_field(pull_config_reg, i))
          PULL_NONE: begin
            pull_up_out[i] <= 1'b0;
            pull_down_out[i] <= 1'b0;
          end
          PULL_DOWN: begin
            pull_up_out[i] <= 1'b0;
            pull_down_out[i] <= 1'b1;
          end
          PULL_UP: begin
            pull_up_out[i] <= 1'b1;
            pull_down_out[i] <= 1'b0;
          end
          PULL_AUTO: begin
            // Follows the synchronised level, so it reinforces the current state
            pull_up_out[i] <= live_vec[i];
            pull_down_out[i] <= !live_vec[i];
          end
        endcase
      end
    end
  end

endmodule

// ==== tb/tb_wake_input_detector.sv ====
// Self-checking testbench for the wake input detector
`timescale 1ns/1ps
module tb_wake_input_detector;
  import wkd_pkg::*;
  logic clk_in, resetn_in, psel, penable, pwrite, timer_a, timer_b, pready, pslverr, irq, wake, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] pins, pin_w, rel;
  logic [1:0] mode;
  logic [2:0] pu, pd;
  int mismatches, checks;
  // Short filter counts keep the run brief; expectations use 20 and 80
  wkd_top #(.SHORT_CYC(20), .LONG_CYC(80)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .wake_pin_in(pin_w[2:0]),
    .alt_output_pin_in(pin_w[4:3]), .timer_a_on_in(timer_a), .timer_b_on_in(timer_b),
    .dev_mode_in(mode), .pull_up_out(pu), .pull_down_out(pd), .irq_out(irq), .wake_out(wake));
  wkd_pin_model i_pins (.clk_in(clk_in), .drive_en_in(~rel), .drive_val_in(pins),
    .pull_up_in(pu), .pull_down_in(pd), .pin_out(pin_w));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask
  task automatic setp(input logic [4:0] p);
    @(posedge clk_in);
    pins <= p;
  endtask
  task automatic wait_wake(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (60) begin
      @(posedge clk_in);
      if (wake === 1'b1) seen = 1'b1;
    end
    chk(seen, exp, "wake pulse");
  endtask
  initial begin
    resetn_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer_a = 1'b0;
    timer_b = 1'b0;
    mode = 2'h0;
    pins = 5'h00;
    rel = 5'h00;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    for (int k = 0; k < 10; k++) begin
      rd(8'(4 * k), 32'h0, "reset value");
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1, "error response");
    setp(5'h05);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, OFS_PULL, 32'(c * 21));
      repeat (6) @(posedge clk_in);
      chk({pu, pd}, c == 3 ? 6'h2a : {{3{c[1]}}, {3{c[0]}}}, "pulls");
    end
    rd(OFS_LEVEL, 32'h05, "levels");
    // Let the pull currents alone set the wake pins
    rel <= 5'h07;
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, OFS_PULL, 32'(c * 21));
      repeat (6) @(posedge clk_in);
      rd(OFS_LEVEL, c == 1 ? 32'h0 : 32'h7, "pulled levels");
    end
    rel <= 5'h00;
    // Pin 1 falls on re-drive; its edge must pass while wakes are still off
    repeat (40) @(posedge clk_in);
    apb(1'b1, OFS_WAKE_EN, 32'h1f);
    apb(1'b1, OFS_INT_EN, 32'h1f);
    apb(1'b1, OFS_INT_CLR, 32'h1f);
    setp(5'h04);
    repeat (10) @(posedge clk_in);
    setp(5'h05);
    repeat (40) @(posedge clk_in);
    rd(OFS_SRC, 32'h0, "flags after glitch");
    setp(5'h04);
    repeat (40) @(posedge clk_in);
    rd(OFS_SRC, 32'h1, "flag on fall");
    chk(irq, 1'b1, "interrupt");
    apb(1'b1, OFS_INT_CLR, 32'h1f);
    setp(5'h05);
    repeat (40) @(posedge clk_in);
    rd(OFS_SRC, 32'h1, "flag on rise");
    apb(1'b1, OFS_INT_CLR, 32'h1f);
    rd(OFS_SRC, 32'h0, "flag after clear");
    chk(irq, 1'b0, "interrupt after clear");
    apb(1'b1, OFS_FILT, 32'h1);
    setp(5'h04);
    repeat (40) @(posedge clk_in);
    setp(5'h05);
    repeat (100) @(posedge clk_in);
    rd(OFS_SRC, 32'h0, "flags after short pulse");
    setp(5'h04);
    repeat (100) @(posedge clk_in);
    rd(OFS_SRC, 32'h1, "flag after long filter");
    apb(1'b1, OFS_FILT, 32'h0);
    for (int m = 2; m < 4; m++) begin
      @(posedge clk_in);
      mode <= 2'(m);
      setp(5'(7 - m));
      wait_wake(1'b1);
      chk(irq, 1'b0, "interrupt while asleep");
    end
    apb(1'b1, OFS_WAKE_EN, 32'h1e);
    setp(5'h05);
    wait_wake(1'b0);
    mode <= 2'h0;
    apb(1'b1, OFS_WAKE_EN, 32'h1f);
    apb(1'b1, OFS_FILT, 32'h2);
    apb(1'b1, OFS_INT_CLR, 32'h1f);
    setp(5'h04);
    repeat (40) @(posedge clk_in);
    rd(OFS_LEVEL, 32'h05, "held level");
    rd(OFS_SRC, 32'h0, "flags with window shut");
    timer_a <= 1'b1;
    repeat (40) @(posedge clk_in);
    timer_a <= 1'b0;
    rd(OFS_SRC, 32'h1, "flag in window");
    rd(OFS_LEVEL, 32'h04, "sampled level");
    apb(1'b1, OFS_FILT, 32'h3);
    apb(1'b1, OFS_INT_CLR, 32'h1f);
    setp(5'h05);
    timer_a <= 1'b1;
    repeat (40) @(posedge clk_in);
    timer_a <= 1'b0;
    rd(OFS_SRC, 32'h0, "flag with other timer");
    timer_b <= 1'b1;
    repeat (40) @(posedge clk_in);
    timer_b <= 1'b0;
    rd(OFS_SRC, 32'h1, "flag in second window");
    setp(5'h0d);
    repeat (40) @(posedge clk_in);
    rd(OFS_ALT_SRC, 32'h1, "alternate flag");
    rd(OFS_INT_STAT, 32'h9, "all flags");
    chk(irq, 1'b1, "alternate interrupt");
    mode <= 2'h1;
    rd(OFS_MODE, 32'h1, "stop mode readback");
    chk(irq, 1'b1, "interrupt in stop mode");
    tally_and_finish();
  end
endmodule

// ==== tb/wkd_chk_sva.sv ====
// Port checker for the wake input detector, bound to its top module
`timescale 1ns/1ps
module wkd_chk
  import wkd_pkg::*;
#(
  parameter int SHORT_CYC = FILT_SHORT_CYC,
  parameter int LONG_CYC = FILT_LONG_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [1:0] dev_mode_in,
  input wire logic [wkd_pkg::WKD_NPIN-1:0] pull_up_out,
  input wire logic [wkd_pkg::WKD_NPIN-1:0] pull_down_out,
  input wire logic irq_out,
  input wire logic wake_out
);
  import wkd_pkg::*;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------------------------------
  // Shadow of the pull word; age lets the registered pulls settle
  // ----------------------------------------------------------------
  logic [5:0] pull_reg;
  logic [1:0] age_reg;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pull_reg <= 6'h00;
      age_reg <= 2'h0;
    end else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == OFS_PULL) begin
      pull_reg <= pwdata_in[5:0];
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ready_wait;
    psel_in && penable_in && !pready_out |=> pready_out;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("no ready after one wait state");
  property p_ready_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_slverr;
    pslverr_out |-> pready_out && prdata_out == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("error response outside ready");
  property p_rdata_idle;
    !pready_out |-> prdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside ready");
  property p_irq_mode;
    irq_out |-> !$past(dev_mode_in[1]);
  endproperty
  a_irq_mode: assert property (p_irq_mode)
    else $error("interrupt in a low-power mode");
  property p_wake_mode;
    wake_out |-> $past(dev_mode_in[1]) ##1 !wake_out;
  endproperty
  a_wake_mode: assert property (p_wake_mode)
    else $error("wake outside low-power mode or too long");
  for (genvar i = 0; i < WKD_NPIN; i++) begin : g_pull
    property p_pull_code;
      age_reg == 2'h3 |-> (&pull_reg[2*i +: 2] ? (pull_up_out[i] ^ pull_down_out[i])
        : ({pull_up_out[i], pull_down_out[i]} == pull_reg[2*i +: 2]));
    endproperty
    a_pull_code: assert property (p_pull_code)
      else $error("pull enables disagree with code");
  end
  property p_pull_excl;
    (pull_up_out & pull_down_out) == 3'h0;
  endproperty
  a_pull_excl: assert property (p_pull_excl)
    else $error("pull-up and pull-down together");
endmodule
bind wkd_top wkd_chk #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) i_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .paddr_in(paddr_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .dev_mode_in(dev_mode_in), .pull_up_out(pull_up_out), .pull_down_out(pull_down_out),
  .irq_out(irq_out), .wake_out(wake_out));

// ==== tb/wkd_pin_model.sv ====
// Switches and sensor circuits that drive the wake and alternate pins
`timescale 1ns/1ps
module wkd_pin_model (
  input wire logic clk_in,
  input wire logic [4:0] drive_en_in,
  input wire logic [4:0] drive_val_in,
  input wire logic [2:0] pull_up_in,
  input wire logic [2:0] pull_down_in,
  output logic [4:0] pin_out
);
  logic [4:0] up;
  logic [4:0] down;
  logic [4:0] wander_reg;
  assign up = {2'h0, pull_up_in};
  assign down = {2'h0, pull_down_in};
  // An open pin with no pull has no defined level, so it flips every cycle
  always_ff @(posedge clk_in) begin
    wander_reg <= ~pin_out;
  end
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      if (drive_en_in[k]) begin
        pin_out[k] = drive_val_in[k];
      end else if (up[k] || down[k]) begin
        pin_out[k] = up[k];
      end else begin
        pin_out[k] = wander_reg[k];
      end
    end
  end
endmodule
